// ==== core/lvg_pkg.sv ====
// Shared constants for the low-voltage pin bank
package lvg_pkg;
	localparam int          NPINS        = 4;
	localparam int          CTRL_W       = 16;
	// Control word field positions
	localparam int          F_DIR        = 0;
	localparam int          F_DIN        = 1;
	localparam int          F_DOUT       = 2;
	localparam int          F_SCHMITT    = 3;
	localparam int          F_FILT_LO    = 4;
	localparam int          F_EDGE_LO    = 6;
	localparam int          F_KEEPER     = 8;
	localparam int          F_ODRAIN     = 9;
	localparam int          F_STRENGTH   = 10;
	localparam int          F_PULL_ON    = 11;
	localparam int          F_PULL_LO    = 12;
	localparam int          F_SLEW_LO    = 14;
	// Reset: input, hysteresis on, pull on, 100k pull-up, slow slew
	localparam logic [15:0] CTRL_RST     = 16'h3808;
	// Filter time codes
	localparam logic [1:0]  FILT_NONE    = 2'h0;
	localparam logic [1:0]  FILT_10      = 2'h1;
	localparam logic [1:0]  FILT_20      = 2'h2;
	localparam logic [1:0]  FILT_30      = 2'h3;
	localparam int          FILT_10_MS   = 10;
	localparam int          FILT_20_MS   = 20;
	localparam int          FILT_30_MS   = 30;
	// Edge event codes
	localparam logic [1:0]  EDGE_NONE    = 2'h0;
	localparam logic [1:0]  EDGE_FALL    = 2'h1;
	localparam logic [1:0]  EDGE_RISE    = 2'h2;
	localparam logic [1:0]  EDGE_BOTH    = 2'h3;
	// Clock and millisecond tick
	localparam int          CLK_HZ       = 200_000_000;
	localparam int          TICK_MS      = 1;
	localparam int          TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
endpackage : lvg_pkg

// ==== core/lvg_tick.sv ====
// Millisecond enable pulse divider
`timescale 1ns/1ps
module lvg_tick
#(
	parameter int CYCLES = lvg_pkg::TICK_CYCLES
)
(
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst_n,
	// One-cycle enable every CYCLES clocks
	output logic      tick
);
	import lvg_pkg::*;

	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic        tick_r;
	logic        tick_nxt;

	// Free-running count, wraps at CYCLES
	always_comb
	begin
		tick_nxt = 1'b0;
		cnt_nxt  = cnt_r + 32'h0000_0001;
		if (cnt_r == 32'(CYCLES - 1))
		begin
			cnt_nxt  = 32'h0000_0000;
			tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			cnt_r  <= 32'h0000_0000;
			tick_r <= 1'b0;
		end
		else
		begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick = tick_r;
endmodule : lvg_tick

// ==== core/lvg_filter.sv ====
// Pin synchroniser and millisecond debounce filter for one pin
`timescale 1ns/1ps
module lvg_filter
(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// Timing and setting
	input  wire logic       tick,
	input  wire logic [1:0] filt_sel,
	// Pin and result
	input  wire logic       pin_in,
	output logic            level
);
	import lvg_pkg::*;

	logic       sync1_r;
	logic       sync2_r;
	logic       level_r;
	logic       level_nxt;
	logic [4:0] cnt_r;
	logic [4:0] cnt_nxt;
	logic [4:0] need;

	// Stable time needed in whole milliseconds
	always_comb
	begin
		unique case (filt_sel)
			FILT_10: need = 5'(FILT_10_MS);
			FILT_20: need = 5'(FILT_20_MS);
			FILT_30: need = 5'(FILT_30_MS);
			FILT_NONE: need = 5'h00;
		endcase
	end

	// A change is accepted once it has held through need consecutive ticks;
	// the first tick may come early, so the hold can be up to 1 ms short
	always_comb
	begin
		level_nxt = level_r;
		cnt_nxt   = cnt_r;
		if (filt_sel == FILT_NONE)
		begin
			level_nxt = sync2_r;
			cnt_nxt   = 5'h00;
		end
		else if (sync2_r == level_r)
			cnt_nxt = 5'h00;
		else if (tick)
		begin
			if (cnt_r + 5'h01 >= need)
			begin
				level_nxt = sync2_r;
				cnt_nxt   = 5'h00;
			end
			else
				cnt_nxt = cnt_r + 5'h01;
		end
	end

	// Two-stage synchroniser; only the second stage is read
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			level_r <= 1'b0;
			cnt_r   <= 5'h00;
		end
		else
		begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
			level_r <= level_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	assign level = level_r;
endmodule : lvg_filter

// ==== core/lvg_bank.sv ====
// Four low-voltage general purpose pins with per-pin control words
// Contract
// - Four pins, each independently set as input or output.
// - Each pin has its own sixteen-bit control word.
// - Direction bit: 0 input (reset), 1 output.
// - Input level bit reads the pin's present level; the code returns the debounced level when a filter is set.
// - Output level bit drives the pin low or high when output.
// - Filter field: none, 10, 20 or 30 ms debounce; none at reset.
// - Edge field: none, falling, rising or both; none at reset.
// - Open-drain bit: 0 push-pull (reset), 1 open-drain.
// - Keeper bit: 0 off (reset), 1 on.
// - Strength bit: 0 gives 4 mA (reset), 1 gives 8 mA.
// - Pull enable bit: 0 off, 1 on; on at reset.
// - Pull kind: 10k down, 10k up, 100k down, 100k up (reset).
// - Slew field: slow (reset), normal, fast, very fast.
`timescale 1ns/1ps
module lvg_bank
	import lvg_pkg::*;
#(
	parameter int NP       = lvg_pkg::NPINS,
	parameter int MS_TICKS = lvg_pkg::TICK_CYCLES
)
(
	// Clock and reset
	input  wire logic                    mclk,
	input  wire logic                    rst_n,
	// Control word write port
	input  wire logic                    wr_en,
	input  wire logic [1:0]              wr_sel,
	input  wire logic [CTRL_W-1:0]       wr_data,
	// Control word read port
	input  wire logic [1:0]              rd_sel,
	output logic      [CTRL_W-1:0]       rd_data,
	// Event flags and interrupt
	input  wire logic [NP-1:0]           evt_clr,
	output logic      [NP-1:0]           evt_flag,
	output logic                         irq,
	// Pins
	input  wire logic [NP-1:0]           pin_i,
	output logic      [NP-1:0]           pin_o,
	output logic      [NP-1:0]           pin_oe,
	// Pad settings
	output logic      [NP-1:0]           pad_schmitt,
	output logic      [NP-1:0]           pad_keeper,
	output logic      [NP-1:0]           pad_strength,
	output logic      [NP-1:0]           pad_pull_on,
	output logic      [2*NP-1:0]         pad_pull_kind,
	output logic      [2*NP-1:0]         pad_slew
);
	import lvg_pkg::*;

	// Writable control words; the input level bit is not stored here
	logic [CTRL_W-1:0] ctrl_r   [NP];
	logic [CTRL_W-1:0] ctrl_nxt [NP];
	logic [NP-1:0]     lvl;
	logic [NP-1:0]     lvl_d_r;
	logic [NP-1:0]     evt_r;
	logic [NP-1:0]     evt_nxt;
	logic [NP-1:0]     hit;
	logic              irq_r;
	logic [CTRL_W-1:0] rd_r;
	logic [CTRL_W-1:0] rd_nxt;
	logic [NP-1:0]     po_r;
	logic [NP-1:0]     po_nxt;
	logic [NP-1:0]     poe_r;
	logic [NP-1:0]     poe_nxt;
	logic              tick;

	// Two-bit field extraction used for several fields
	function automatic logic [1:0] fld2(input logic [CTRL_W-1:0] w, input int lo);
		fld2 = w[lo +: 2];
	endfunction : fld2

	// Shared millisecond timebase for all filters
	lvg_tick #(
		.CYCLES (MS_TICKS)
	) u_tick (
		.mclk  (mclk),
		.rst_n (rst_n),
		.tick  (tick)
	);

	// One synchroniser and debounce per pin
	genvar g;
	generate
		for (g = 0; g < NP; g++)
		begin : g_pin
			lvg_filter u_filt (
				.mclk     (mclk),
				.rst_n    (rst_n),
				.tick     (tick),
				.filt_sel (fld2(ctrl_r[g], F_FILT_LO)),
				.pin_in   (pin_i[g]),
				.level    (lvl[g])
			);
		end
	endgenerate

	// Software writes the selected word; input level bit is read-only
	always_comb
	begin
		for (int i = 0; i < NP; i++)
		begin
			ctrl_nxt[i] = ctrl_r[i];
			if (wr_en && (wr_sel == 2'(i)))
			begin
				ctrl_nxt[i]        = wr_data;
				ctrl_nxt[i][F_DIN] = 1'b0;
			end
		end
	end

	// Pin drive: push-pull drives both levels, open-drain only pulls low
	always_comb
	begin
		for (int i = 0; i < NP; i++)
		begin
			po_nxt[i]  = ctrl_r[i][F_DOUT];
			poe_nxt[i] = 1'b0;
			if (ctrl_r[i][F_DIR])
			begin
				if (ctrl_r[i][F_ODRAIN])
					poe_nxt[i] = ~ctrl_r[i][F_DOUT];
				else
					poe_nxt[i] = 1'b1;
			end
		end
	end

	// Edge events on the filtered level; set wins over a same-cycle clear
	always_comb
	begin
		for (int i = 0; i < NP; i++)
		begin
			unique case (fld2(ctrl_r[i], F_EDGE_LO))
				EDGE_FALL: hit[i] = lvl_d_r[i] & ~lvl[i];
				EDGE_RISE: hit[i] = ~lvl_d_r[i] & lvl[i];
				EDGE_BOTH: hit[i] = lvl_d_r[i] ^ lvl[i];
				EDGE_NONE: hit[i] = 1'b0;
			endcase
		end
		evt_nxt = (evt_r & ~evt_clr) | hit;
	end

	// Read data: stored word with the live filtered level merged in
	always_comb
	begin
		rd_nxt        = ctrl_r[rd_sel];
		rd_nxt[F_DIN] = lvl[rd_sel];
	end

	// Registered state; every top output comes from here
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < NP; i++)
				ctrl_r[i] <= CTRL_RST;
			lvl_d_r <= '0;
			evt_r   <= '0;
			irq_r   <= 1'b0;
			rd_r    <= '0;
			po_r    <= '0;
			poe_r   <= '0;
		end
		else
		begin
			for (int i = 0; i < NP; i++)
				ctrl_r[i] <= ctrl_nxt[i];
			lvl_d_r <= lvl;
			evt_r   <= evt_nxt;
			irq_r   <= |evt_nxt;
			rd_r    <= rd_nxt;
			po_r    <= po_nxt;
			poe_r   <= poe_nxt;
		end
	end

	// Pad settings are straight register fields
	always_comb
	begin
		for (int i = 0; i < NP; i++)
		begin
			pad_schmitt[i]          = ctrl_r[i][F_SCHMITT];
			pad_keeper[i]           = ctrl_r[i][F_KEEPER];
			pad_strength[i]         = ctrl_r[i][F_STRENGTH];
			pad_pull_on[i]          = ctrl_r[i][F_PULL_ON];
			pad_pull_kind[2*i +: 2] = fld2(ctrl_r[i], F_PULL_LO);
			pad_slew[2*i +: 2]      = fld2(ctrl_r[i], F_SLEW_LO);
		end
	end

	assign rd_data  = rd_r;
	assign evt_flag = evt_r;
	assign irq      = irq_r;
	assign pin_o    = po_r;
	assign pin_oe   = poe_r;
endmodule : lvg_bank

// ==== core/lvg_dummy_unused.sv ====
// Reserved slot for later pin bank extensions; holds no logic

// ==== testbench/lvg_checker.sv ====
// Assertion checker for the low-voltage pin bank
`timescale 1ns/1ps
module lvg_checker
(
	// Clock and reset
	input wire logic        mclk,
	input wire logic        rst_n,
	// Writes and clears
	input wire logic        wr_en,
	input wire logic [1:0]  wr_sel,
	input wire logic [15:0] wr_data,
	input wire logic [3:0]  evt_clr,
	// Watched outputs
	input wire logic [3:0]  evt_flag,
	input wire logic        irq,
	input wire logic [3:0]  pin_o,
	input wire logic [3:0]  pin_oe,
	input wire logic [3:0]  pad_keeper,
	input wire logic [3:0]  pad_strength,
	input wire logic [3:0]  pad_schmitt,
	input wire logic [3:0]  pad_pull_on,
	input wire logic [7:0]  pad_pull_kind,
	input wire logic [7:0]  pad_slew
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Writes to the first and the last pin
	sequence s_wr0;
		wr_en && wr_sel == 2'h0;
	endsequence
	sequence s_wr3;
		wr_en && wr_sel == 2'h3;
	endsequence
	AST_IRQ: assert property (irq == |evt_flag)
		else $error("irq differs from flags");
	AST_HOLD: assert property (evt_flag[2] && !evt_clr[2] |=> evt_flag[2])
		else $error("flag dropped uncleared");
	AST_CLR: assert property ($fell(evt_flag[2]) |-> $past(evt_clr[2]))
		else $error("flag fell without clear");
	AST_KEEP: assert property (s_wr0 |=> pad_keeper[0] == $past(wr_data[8]))
		else $error("keeper wrong");
	AST_STR: assert property (s_wr3 |=> pad_strength[3] == $past(wr_data[10]))
		else $error("strength wrong");
	AST_SCH: assert property (s_wr0 |=> pad_schmitt[0] == $past(wr_data[3]))
		else $error("schmitt wrong");
	AST_PULL: assert property (s_wr3 |=> pad_pull_on[3] == $past(wr_data[11]))
		else $error("pull enable wrong");
	AST_KIND: assert property (s_wr3 |=> pad_pull_kind[7:6] == $past(wr_data[13:12]))
		else $error("pull kind wrong");
	AST_SLEW: assert property (s_wr0 |=> pad_slew[1:0] == $past(wr_data[15:14]))
		else $error("slew wrong");
	AST_DIR: assert property (s_wr0 |=> ##1 pin_oe[0] ==
		($past(wr_data[0], 2) && !($past(wr_data[9], 2) && $past(wr_data[2], 2))))
		else $error("enable wrong");
	AST_OUT: assert property (s_wr0 |=> ##1 pin_o[0] == $past(wr_data[2], 2))
		else $error("out level wrong");
	AST_STILL: assert property (!wr_en [*2] |=> $stable(pin_oe) && $stable(pin_o))
		else $error("pins moved without write");
endmodule : lvg_checker

bind lvg_bank lvg_checker u_chk (.mclk, .rst_n, .wr_en, .wr_sel, .wr_data, .evt_clr,
	.evt_flag, .irq, .pin_o, .pin_oe, .pad_keeper, .pad_strength,
	.pad_schmitt, .pad_pull_on, .pad_pull_kind, .pad_slew);

// ==== testbench/lvg_pins.sv ====
// Model of the external circuits on the four pins
`timescale 1ns/1ps
module lvg_pins
(
	// Device pad drive
	input  wire logic [3:0] pin_o,
	input  wire logic [3:0] pin_oe,
	// External drive ordered by the bench
	input  wire logic [3:0] ext_en,
	input  wire logic [3:0] ext_lvl,
	// Resolved pin level
	output logic      [3:0] pin_i
);
	// Board pull-up holds a released pin high, which also covers open drain
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			pin_i[i] = pin_oe[i] ? pin_o[i] : (ext_en[i] ? ext_lvl[i] : 1'b1);
	end
endmodule : lvg_pins

// ==== testbench/tb_lvg_bank.sv ====
// Self-checking bench for the low-voltage pin bank
`timescale 1ns/1ps
module tb_lvg_bank;
	import lvg_pkg::*;
	localparam int MS = 20;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        wr_en = 1'b0;
	logic [1:0]  wr_sel = 2'h0;
	logic [1:0]  rd_sel = 2'h0;
	logic [15:0] wr_data = 16'h0000;
	logic [15:0] rd_data;
	logic [15:0] w [4];
	logic [3:0]  evt_clr = 4'h0;
	logic [3:0]  ext_en = 4'h0;
	logic [3:0]  ext_lvl = 4'h0;
	logic [3:0]  evt_flag, pin_i, pin_o, pin_oe;
	logic        irq, lv;
	logic        chk = 1'b0;
	logic        chk_d = 1'b0;
	logic [31:0] seed = 32'hf192;
	logic [16:0] e_n;
	logic [16:0] expq [$];
	int          num_errors = 0;
	int          n_tests = 0;
	int          cyc = 0;

	always #2.5 mclk = ~mclk;

	lvg_bank #(.MS_TICKS(MS)) u_lvg_bank (.mclk, .rst_n, .wr_en, .wr_sel, .wr_data,
		.rd_sel, .rd_data, .evt_clr, .evt_flag, .irq, .pin_i, .pin_o, .pin_oe,
		.pad_schmitt(), .pad_keeper(), .pad_strength(), .pad_pull_on(),
		.pad_pull_kind(), .pad_slew());
	lvg_pins u_lvg_pins (.pin_o, .pin_oe, .ext_en, .ext_lvl, .pin_i);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task automatic give_verdict;
		$display("Checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	task automatic wr(input logic [1:0] s, input logic [15:0] d);
		@(posedge mclk);
		wr_en <= 1'b1;
		wr_sel <= s;
		wr_data <= d;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask : wr

	// Note an expected word (k=0) or flag set (k=1) and ask for its sample
	task automatic look(input logic k, input logic [1:0] s, input logic [15:0] e);
		@(posedge mclk);
		rd_sel <= s;
		expq.push_back({k, e});
		chk <= 1'b1;
		@(posedge mclk);
		chk <= 1'b0;
	endtask : look

	task automatic clr;
		@(posedge mclk);
		evt_clr <= 4'hf;
		@(posedge mclk);
		evt_clr <= 4'h0;
	endtask : clr

	// Results show one edge after the request; compare mid-cycle when settled
	always @(posedge mclk)
		chk_d <= chk;
	always @(negedge mclk)
	begin
		if (chk_d)
		begin
			e_n = expq.pop_front();
			cmp(e_n[16] ? "flags" : "word", e_n[15:0],
				e_n[16] ? {11'h000, irq, evt_flag} : rd_data);
		end
	end

	// Hang guard, far above the expected run length
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			give_verdict();
		end
	end

	initial
	begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (8) @(posedge mclk);
		// Reset words; released pins read high
		for (int p = 0; p < 4; p++)
			look(1'b0, p[1:0], CTRL_RST | 16'h0002);
		// Random words; debounce and events masked so levels settle at once
		repeat (2)
		begin
			for (int p = 0; p < 4; p++)
			begin
				seed = lfsr(seed);
				w[p] = seed[15:0] & 16'hff0d;
				wr(p[1:0], w[p]);
			end
			repeat (8) @(posedge mclk);
			for (int p = 0; p < 4; p++)
				look(1'b0, p[1:0], w[p] | {14'h0000, w[p][0] ? w[p][2] : 1'b1, 1'b0});
		end
		// Every edge setting against a fall then a rise on pin 2
		for (int c = 0; c < 4; c++)
		begin
			wr(2'h2, {8'h00, c[1:0], 6'h00});
			ext_en <= 4'h4;
			ext_lvl <= 4'h4;
			repeat (8) @(posedge mclk);
			clr;
			ext_lvl <= 4'h0;
			repeat (8) @(posedge mclk);
			look(1'b1, 2'h0, {11'h000, c[0], c[0] ? 4'h4 : 4'h0});
			clr;
			ext_lvl <= 4'h4;
			repeat (8) @(posedge mclk);
			look(1'b1, 2'h0, {11'h000, c[1], c[1] ? 4'h4 : 4'h0});
		end
		clr;
		lv = 1'b1;
		// A change reads back only after the filter time, which can be up to 1 ms short
		for (int f = 1; f < 4; f++)
		begin
			wr(2'h2, {10'h000, f[1:0], 4'h0});
			repeat (8) @(posedge mclk);
			ext_lvl <= ext_lvl ^ 4'h4;
			// Code f means f times 10 ms; old level must stand until near the end
			repeat ((f * FILT_10_MS - 1) * MS - 6) @(posedge mclk);
			look(1'b0, 2'h2, {10'h000, f[1:0], 2'h0, lv, 1'b0});
			lv = ~lv;
			repeat (MS + 12) @(posedge mclk);
			look(1'b0, 2'h2, {10'h000, f[1:0], 2'h0, lv, 1'b0});
		end
		repeat (4) @(posedge mclk);
		give_verdict();
	end
endmodule : tb_lvg_bank
